// ===== dv/host_link.sv
// host model: external serial clock, chain data and capture
`timescale 1ns/1ns
module host_link (
  input wire logic go,
  input wire logic inv,
  input wire logic sdo,
  input wire logic [17:0] chain_bits,
  output logic ext_sclk,
  output logic chain_in,
  output logic [35:0] got
);
  // ====
  // warm-up edges, then per go four lead-in edges and 36 data periods;
  // clock stands still between frames
  initial begin
    ext_sclk = '0;
    chain_in = '0;
    repeat (8) #15 ext_sclk = !ext_sclk;
    forever begin
      @(posedge go);
      ext_sclk = inv;
      // word loads on edge 4; chain bits go in on edges 5 to 22
      for (int i = 0; i < 40; i++) begin
        chain_in = (i > 3 && i < 22) ? chain_bits[21 - i] : !chain_in;
        #15 ext_sclk = !inv;
        #15 ext_sclk = inv;
        // sampled at the far edge, where the bit is valid
        if (i > 2 && i < 39) got[38 - i] = sdo;
      end
    end
  end
endmodule // host_link

// ===== dv/serial_result_port_sva.sv
// checker for the serial result port
`timescale 1ns/1ns
module serial_result_port_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sclk_out_en,
  input wire logic sclk_out,
  input wire logic frame_marker,
  input wire logic shared_pins_en
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ====
  // frame opens on a marker edge while the device drives the clock
  sequence frame_open;
    sclk_out_en && $changed(frame_marker);
  endsequence
  // the first clock edge of a frame follows the marker by two cycles
  sequence clock_starts;
    $changed(sclk_out);
  endsequence
  chk_pins_mode: assert property (shared_pins_en |-> !sclk_out_en) else $error("clk");
  chk_frame_hold: assert property (frame_open ##2 clock_starts |=> $stable(frame_marker) [*8])
    else $error("short frame");
  chk_ar_accept: assert property (s_axi_arvalid |-> ##[0:2] s_axi_arready) else $error("ar");
  chk_aw_accept: assert property (s_axi_awvalid |-> ##[0:2] s_axi_awready) else $error("aw");
  chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read answer");
  chk_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("no write answer");
  chk_rd_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read twice");
  chk_wr_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write twice");
endmodule // serial_result_port_sva
// one checker beside each port instance
bind serial_result_port serial_result_port_sva serial_result_port_sva_inst (.aclk(aclk),
  .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .sclk_out_en(sclk_out_en),
  .sclk_out(sclk_out),
  .frame_marker(frame_marker), .shared_pins_en(shared_pins_en));

// ===== dv/test_serial_result_port.sv
// bench for the serial result port
`timescale 1ns/1ns
module test_serial_result_port;
  import serial_port_pkg::*;
  logic aclk = '0;
  logic aresetn = '0;
  logic awv = '0, wv = '0, arv = '0, start = '0, go = '0, inv = '0;
  logic pol, rdm, lst, awr, wrd, bv, arr, rv, sdo, fm, sck, sen, p7, p8, p9, pen, esck, cin;
  logic [3:0] awa = '0, ara = '0;
  logic [31:0] wd = '0, rdat, d, seed = 32'h0000_0041;
  logic [17:0] v = '0, old, chain = '0, sh;
  logic [35:0] got;
  int fails = 0, tests_run = 0;
  // ====
  // clock, port and host model
  always #2 aclk = ~aclk;
  serial_result_port serial_result_port_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(), .s_axi_bvalid(bv), .s_axi_bready(1'h1),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(), .s_axi_rvalid(rv), .s_axi_rready(1'h1), .ext_sclk(esck), .read_start(start),
    .read_mode_or_chain_in(cin), .serial_result_out(sdo), .frame_marker(fm), .sclk_out(sck),
    .sclk_out_en(sen), .parallel_bit7(p7), .parallel_bit8(p8), .parallel_bit9(p9),
    .shared_pins_en(pen));
  host_link host_link_inst (.go(go), .inv(inv), .sdo(sdo), .chain_bits(chain),
    .ext_sclk(esck), .chain_in(cin), .got(got));
  // xorshift source, fixed seed
  function automatic logic [17:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[17:0];
  endfunction
  // compare and count
  task automatic chk(string nm, logic [35:0] seen, logic [35:0] exp);
    tests_run++;
    if (seen !== exp) fails++;
    if (seen !== exp) $display("BAD %s exp %h seen %h", nm, exp, seen);
  endtask
  // bus cycles: each channel held until its own ready edge
  task automatic wr(logic [3:0] a, logic [31:0] x);
    {awa, wd, awv, wv} <= {a, x, 2'h3};
    do begin
      @(posedge aclk);
      if (awr) awv <= '0;
      if (wrd) wv <= '0;
    end while (!bv);
  endtask
  task automatic rd(logic [3:0] a);
    {ara, arv} <= {a, 1'h1};
    do @(posedge aclk); while (!arr);
    arv <= '0;
    do @(posedge aclk); while (!rv);
    d = rdat;
  endtask
  // conversion, then poll busy and fetch the result
  task automatic conv(logic [17:0] x);
    wr(conv_addr, {14'h0, x});
    do rd(status_addr); while (d[0]);
    rd(result_addr);
  endtask
  task automatic report_and_stop();
    $display("checks %0d fails %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // watchdog, far past the roughly 1300 cycles of the run
  initial begin
    #100000;
    fails++;
    report_and_stop();
  end
  // reset, parallel modes, internal clock, host clock with chain
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= '1;
    repeat (2) @(posedge aclk);
    rd(ctrl_addr);
    chk("ctrl", d, ctrl_reset);
    for (int m = 0; m < 3; m++) begin
      v = m ? xs() : 18'h3_ffff;
      wr(ctrl_addr, 32'(m));
      conv(v);
      chk("result", d, v);
      chk("pins", {p9, p8, p7, pen}, {v[9:7], 1'h1});
    end
    for (int k = 0; k < 4; k++) begin
      pol = k[0];
      rdm = k[0] ^ k[1];
      old = v;
      v = xs();
      wr(ctrl_addr, {26'h0, rdm, k[1], pol, 3'h3});
      repeat (8) @(posedge aclk);
      chk("idle", {pen, sen, fm}, {2'h1, pol});
      wr(conv_addr, {14'h0, v});
      start <= '1;
      do @(posedge aclk); while (fm === pol);
      do begin
        @(posedge aclk);
        if (sck !== lst && sck === !k[1]) sh = {sh[16:0], sdo};
        lst = sck;
      end while (fm !== pol);
      start <= '0;
      chk("serial", sh, rdm ? old : v);
      repeat (10) @(posedge aclk);
    end
    for (int k = 0; k < 2; k++) begin
      v = xs();
      chain = xs();
      inv <= k[0];
      wr(ctrl_addr, {27'h0, k[0], 4'h7});
      conv(v);
      chk("source", sen, 1'h0);
      start <= '1;
      repeat (8) @(posedge aclk);
      go <= '1;
      repeat (320) @(posedge aclk);
      {go, start} <= 2'h0;
      chk("own", got[35:18], v);
      chk("chain", got[17:0], chain);
    end
    report_and_stop();
  end
endmodule // test_serial_result_port

// ===== rtl/serial_port_pkg.sv
// constants for the serial result port with shared configuration pins
package serial_port_pkg;
  // ===================================================
  // register map, byte addresses
  localparam logic [3:0] ctrl_addr = 4'h0;
  localparam logic [3:0] result_addr = 4'h4;
  localparam logic [3:0] status_addr = 4'h8;
  localparam logic [3:0] conv_addr = 4'hc;
  // ===================================================
  // control fields
  localparam int ctrl_sel_lsb = 0;
  localparam int ctrl_src_bit = 2;
  localparam int ctrl_pol_bit = 3;
  localparam int ctrl_inv_bit = 4;
  localparam int ctrl_rdm_bit = 5;
  localparam logic [31:0] ctrl_reset = 32'h0000_0000;
  localparam logic [17:0] result_reset = 18'h0_0000;
  // ===================================================
  // interface modes and serial figures
  localparam logic [1:0] mode_serial = 2'h3;
  localparam int result_bits = 18;
  localparam int chain_delay = 18;
  localparam int int_clk_div = 4;
  localparam int conv_cycles = 16;
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
endpackage

// ===== rtl/serial_result_port.sv
// serial result port with shared configuration pins and an axi4-lite control slave
//
// Local design decisions: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns
// Function
// R1 - outside interface mode 3 the three shared pins carry parallel bits 7 to 9.
// R2 - in serial mode the marker is active high when the polarity select is low, else low.
// R3 - in serial mode the clock invert select inverts the serial clock sense, internal or external.
// R4 - with external clock the read-mode pin is a chain data input passed to the serial output.
// R5 - in daisy chain the chain input level appears on the output 18 clock periods after start.
// R6 - internal clock with read-mode high shifts the previous result out during conversion.
// R7 - internal clock with read-mode low shifts data out only after conversion completes.
// R8 - the host sets interface select 00 18-bit, 01 16-bit, 10 byte, 11 serial.
// R9 - clock source select low drives the internal clock out, high follows the host clock.
// R10 - with internal clock the marker is asserted at its polarity while output data is valid.
// R11 - with external clock output updates on rising edges, or falling with inversion.
// R12 - the host keeps configuration inputs stable while a transfer is active.
module serial_result_port
  import serial_port_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_sclk,
  input wire logic read_start,
  input wire logic read_mode_or_chain_in,
  output logic serial_result_out,
  output logic frame_marker,
  output logic sclk_out,
  output logic sclk_out_en,
  output logic parallel_bit7,
  output logic parallel_bit8,
  output logic parallel_bit9,
  output logic shared_pins_en
);
  import serial_port_pkg::*;

  // ===================================================
  // control register and bus slave
  logic [31:0] ctrl_reg;
  logic [17:0] result_reg;
  logic [3:0] awaddr_reg;
  logic aw_held_reg, w_held_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic conv_busy_reg;
  logic [4:0] conv_cnt_reg;
  logic [17:0] conv_data_reg;
  logic frame_busy_sync;
  logic [1:0] mode;
  logic src_ext, pol_sel, inv_sel, rdm_sel, serial_mode;
  assign mode = ctrl_reg[ctrl_sel_lsb +: 2];
  assign src_ext = ctrl_reg[ctrl_src_bit];
  assign pol_sel = ctrl_reg[ctrl_pol_bit];
  assign inv_sel = ctrl_reg[ctrl_inv_bit];
  assign rdm_sel = ctrl_reg[ctrl_rdm_bit];
  assign serial_mode = (mode == mode_serial);

  // address and data accepted in either order, response after both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 4'h0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= resp_okay;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (aw_held_reg && w_held_reg && !s_axi_bvalid) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_reg == ctrl_addr || awaddr_reg == conv_addr) ? resp_okay
                                                                           : resp_slverr;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_reg && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_held_reg && !(s_axi_wvalid && s_axi_wready);
    end
  end

  // control writes honour byte strobes; the low byte holds every field
  logic wr_fire;
  assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= ctrl_reset;
    end else if (wr_fire && awaddr_reg == ctrl_addr && wstrb_reg[0]) begin
      ctrl_reg <= {24'h00_0000, 2'h0, wdata_reg[5:0]};
    end
  end

  // conversion stand-in: a write to conv_addr while not busy loads a new result after a delay
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conv_busy_reg <= 1'b0;
      conv_cnt_reg <= 5'h00;
      conv_data_reg <= result_reset;
      result_reg <= result_reset;
    end else if (wr_fire && awaddr_reg == conv_addr && !conv_busy_reg) begin
      conv_busy_reg <= 1'b1;
      conv_cnt_reg <= 5'(conv_cycles);
      conv_data_reg <= wdata_reg[17:0];
    end else if (conv_busy_reg) begin
      conv_cnt_reg <= conv_cnt_reg - 5'h01;
      if (conv_cnt_reg == 5'h01) begin
        conv_busy_reg <= 1'b0;
        result_reg <= conv_data_reg;
      end
    end
  end

  // reads answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= resp_okay;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= resp_okay;
        unique case (s_axi_araddr)
          ctrl_addr: s_axi_rdata <= ctrl_reg;
          result_addr: s_axi_rdata <= {14'h0000, result_reg};
          status_addr: s_axi_rdata <= {30'h0000_0000, frame_busy_sync, conv_busy_reg};
          conv_addr: s_axi_rdata <= 32'h0000_0000;
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= resp_slverr;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ===================================================
  // shared pins: parallel bits outside serial mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      parallel_bit7 <= 1'b0;
      parallel_bit8 <= 1'b0;
      parallel_bit9 <= 1'b0;
      shared_pins_en <= 1'b0;
    end else begin
      parallel_bit7 <= result_reg[7]; // R1
      parallel_bit8 <= result_reg[8]; // R1
      parallel_bit9 <= result_reg[9]; // R1
      shared_pins_en <= !serial_mode; // R1
    end
  end

  // ===================================================
  // read start: three-stage filter of the pin, counted once stages agree
  logic [2:0] start_pipe_reg;
  logic start_seen_reg;
  logic start_pulse;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_pipe_reg <= 3'h0;
      start_seen_reg <= 1'b0;
    end else begin
      start_pipe_reg <= {start_pipe_reg[1:0], read_start};
      if (start_pipe_reg[2] == start_pipe_reg[1]) begin
        start_seen_reg <= start_pipe_reg[2];
      end
    end
  end
  assign start_pulse = (start_pipe_reg[2] == start_pipe_reg[1]) && start_pipe_reg[2]
                       && !start_seen_reg;

  // ===================================================
  // internal serial clock engine, all on aclk
  logic [1:0] div_reg;
  logic int_active_reg;
  logic [4:0] int_bits_reg;
  logic [17:0] int_shift_reg;
  logic int_pending_reg;
  logic int_go;
  // read during conversion starts at once; after-convert waits for completion
  assign int_go = !src_ext && serial_mode && !int_active_reg
                  && (rdm_sel ? (start_pulse || int_pending_reg) // R6
                              : (int_pending_reg && !conv_busy_reg)); // R7
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_pending_reg <= 1'b0;
    end else if (int_go) begin
      int_pending_reg <= 1'b0;
    end else if (start_pulse && serial_mode && !src_ext) begin
      // a start taken in another mode must not linger into a later internal frame
      int_pending_reg <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_reg <= 2'h0;
      int_active_reg <= 1'b0;
      int_bits_reg <= 5'h00;
      int_shift_reg <= result_reset;
    end else if (int_go) begin
      div_reg <= 2'h0;
      int_active_reg <= 1'b1;
      int_bits_reg <= 5'(result_bits);
      int_shift_reg <= result_reg; // R6
    end else if (int_active_reg) begin
      div_reg <= div_reg + 2'h1;
      if (div_reg == 2'(int_clk_div - 1)) begin
        int_shift_reg <= {int_shift_reg[16:0], 1'b0};
        int_bits_reg <= int_bits_reg - 5'h01;
        if (int_bits_reg == 5'h01) begin
          int_active_reg <= 1'b0;
        end
      end
    end
  end

  // ===================================================
  // external clock domain: chained shift on the host's clock
  logic go_tog_reg;
  logic [2:0] go_tog_pipe_reg;
  logic go_seen_reg;
  logic go_fire;
  logic [17:0] snap_reg;
  logic [17:0] ext_shift_reg;
  logic [5:0] ext_cnt_reg;
  logic ext_busy_x;
  logic [2:0] busy_pipe_reg;
  logic busy_seen_reg;
  logic sclk_eff;
  // event crosses as a toggle; result word held stable while it crosses
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      go_tog_reg <= 1'b0;
      snap_reg <= result_reset;
    end else if (start_pulse && src_ext && serial_mode) begin
      go_tog_reg <= !go_tog_reg;
      snap_reg <= result_reg;
    end
  end
  assign sclk_eff = ext_sclk ^ inv_sel; // R3
  // host clock may stop outside frames, so the toggle is caught on its own edges;
  // the start counts once stages two and three agree: four lead-in edges per frame
  always_ff @(posedge sclk_eff) begin
    go_tog_pipe_reg <= {go_tog_pipe_reg[1:0], go_tog_reg};
    if (go_tog_pipe_reg[2] == go_tog_pipe_reg[1]) begin
      go_seen_reg <= go_tog_pipe_reg[2];
    end
  end
  assign go_fire = (go_tog_pipe_reg[2] == go_tog_pipe_reg[1])
                   && (go_tog_pipe_reg[2] != go_seen_reg);
  // msb stands after the loading edge; each of the next 36 edges moves one bit on
  always_ff @(posedge sclk_eff) begin
    if (go_fire) begin
      ext_shift_reg <= snap_reg; // R4 R11
      ext_cnt_reg <= 6'(2 * chain_delay);
      ext_busy_x <= 1'b1;
    end else if (ext_busy_x) begin
      // chain bit enters at the bottom, reaches the pin 18 periods after the load
      ext_shift_reg <= {ext_shift_reg[16:0], read_mode_or_chain_in}; // R4 R5 R11
      ext_cnt_reg <= ext_cnt_reg - 6'h01;
      if (ext_cnt_reg == 6'h01) begin
        ext_busy_x <= 1'b0;
      end
    end else begin
      // idle edges also clear the power-up unknown, as this domain has no reset
      ext_busy_x <= 1'b0;
    end
  end
  // busy flag back to the bus side through three stages
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_pipe_reg <= 3'h0;
      busy_seen_reg <= 1'b0;
    end else begin
      busy_pipe_reg <= {busy_pipe_reg[1:0], ext_busy_x};
      if (busy_pipe_reg[2] == busy_pipe_reg[1]) begin
        busy_seen_reg <= busy_pipe_reg[2];
      end
    end
  end
  assign frame_busy_sync = int_active_reg || busy_seen_reg;

  // ===================================================
  // serial outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sclk_out <= 1'b0;
      sclk_out_en <= 1'b0;
      frame_marker <= 1'b0;
      serial_result_out <= 1'b0;
    end else begin
      sclk_out_en <= serial_mode && !src_ext; // R9
      sclk_out <= (int_active_reg && div_reg[1]) ^ inv_sel; // R3 R9
      frame_marker <= (serial_mode && int_active_reg) ^ pol_sel; // R2 R10
      // host-clocked word is settled long before the host samples it
      serial_result_out <= src_ext ? ext_shift_reg[17] : int_shift_reg[17]; // R9 R11
    end
  end
endmodule // serial_result_port
